// ==== logic/flash_query_host.sv ====
// Host controller for a banked parallel flash: issues reset, autoselect and query
// sequences, reads words, tracks each bank's mode and checks query data.
// Assumes bank_busy and bank_suspended come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module flash_query_host (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [22:0] cmd_addr,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic rsp_refused,
   output logic [15:0] rsp_data,
   input wire logic [3:0] bank_busy,
   input wire logic [3:0] bank_suspended,
   output logic [15:0] bank_mode,
   output logic [3:0] reset_needed,
   output logic query_mismatch,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [22:0] addr,
   output logic [15:0] dq_out,
   output logic dq_oe,
   input wire logic [15:0] dq_in
);

   // ==========================================================
   // Declarations
   // ==========================================================
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_ISSUE = 3'b010,
      S_WAIT = 3'b100
   } seq_state_t;

   bus_cycle_if bc (); // Link to the pin engine
   seq_state_t state_q; // Sequencer state
   logic [1:0] op_q; // Operation in flight
   logic [22:0] caddr_q; // Address of the operation
   logic [1:0] step_q; // Bus cycle index within the sequence
   logic [1:0] bank_w; // Bank of the operation in flight
   logic [1:0] nbank_w; // Bank of the incoming command
   logic refuse_w; // Incoming command is not allowed now
   flash_host_pkg::mode_t mode_q [flash_host_pkg::BANKS]; // Host view of each bank
   logic [16:0] expect_w; // Expected query word for the current address

   // ==========================================================
   // Helpers
   // ==========================================================
   // Last bus cycle index of each operation
   function automatic logic [1:0] last_step(input logic [1:0] op);
      return (op == flash_host_pkg::OP_AUTOSEL) ? 2'h2 : 2'h0;
   endfunction

   // Address and data of one write cycle; a read uses the command address
   function automatic logic [38:0] seq_word(input logic [1:0] op, input logic [1:0] step,
                                            input logic [22:0] a);
      logic [22:0] base;
      base = {a[flash_host_pkg::BANK_MSB:flash_host_pkg::BANK_LSB], 21'h0};
      case (op)
         // Two unlocks, then the bank address with the command
         flash_host_pkg::OP_AUTOSEL: begin
            case (step)
               2'h0: return {base | 23'(flash_host_pkg::UNLOCK1_ADDR), flash_host_pkg::CMD_UNLOCK1};
               2'h1: return {base | 23'(flash_host_pkg::UNLOCK2_ADDR), flash_host_pkg::CMD_UNLOCK2};
               default: return {base | 23'(flash_host_pkg::UNLOCK1_ADDR), flash_host_pkg::CMD_AUTOSEL};
            endcase
         end
         flash_host_pkg::OP_QUERY: return {base | 23'(flash_host_pkg::QUERY_ADDR), flash_host_pkg::CMD_QUERY};
         // Address does not matter to the device for reset
         flash_host_pkg::OP_RESET: return {a, flash_host_pkg::CMD_RESET};
         default: return {a, 16'h0000};
      endcase
   endfunction

   // Mode a bank falls back to on reset
   function automatic flash_host_pkg::mode_t idle_mode(input logic susp);
      return susp ? flash_host_pkg::MODE_ESR : flash_host_pkg::MODE_READ;
   endfunction

   assign bank_w = caddr_q[flash_host_pkg::BANK_MSB:flash_host_pkg::BANK_LSB];
   assign nbank_w = cmd_addr[flash_host_pkg::BANK_MSB:flash_host_pkg::BANK_LSB];
   assign expect_w = flash_host_pkg::query_expect(caddr_q[7:0]);

   // ==========================================================
   // Admission check
   // ==========================================================
   // Autoselect only from a read mode and never while any bank works; query also
   // from autoselect but not on a busy bank. Reset and read are always sent.
   always_comb begin
      refuse_w = 1'b0;
      case (cmd_op)
         flash_host_pkg::OP_AUTOSEL: begin
            refuse_w = (|bank_busy) || !(mode_q[nbank_w] == flash_host_pkg::MODE_READ ||
                                         mode_q[nbank_w] == flash_host_pkg::MODE_ESR);
         end
         flash_host_pkg::OP_QUERY: begin
            refuse_w = bank_busy[nbank_w] || (mode_q[nbank_w] == flash_host_pkg::MODE_QUERY);
         end
         default: refuse_w = 1'b0;
      endcase
   end

   // ==========================================================
   // Sequencer
   // ==========================================================
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_IDLE;
         op_q <= flash_host_pkg::OP_READ;
         caddr_q <= '0;
         step_q <= 2'h0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         rsp_data <= 16'h0000;
         bc.req <= 1'b0;
         bc.wr <= 1'b0;
         bc.addr <= '0;
         bc.wdata <= 16'h0000;
      end else begin
         rsp_valid <= 1'b0;
         rsp_refused <= 1'b0;
         bc.req <= 1'b0;
         case (state_q)
            S_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  if (refuse_w) begin
                     // Refused commands answer at once and touch no pin
                     rsp_valid <= 1'b1;
                     rsp_refused <= 1'b1;
                     cmd_ready <= 1'b1;
                  end else begin
                     op_q <= cmd_op;
                     caddr_q <= cmd_addr;
                     step_q <= 2'h0;
                     state_q <= S_ISSUE;
                  end
               end
            end
            S_ISSUE: begin
               // One bus cycle of the sequence, in order
               {bc.addr, bc.wdata} <= seq_word(op_q, step_q, caddr_q);
               bc.wr <= (op_q != flash_host_pkg::OP_READ);
               bc.req <= 1'b1;
               state_q <= S_WAIT;
            end
            S_WAIT: begin
               if (bc.done) begin
                  if (step_q == last_step(op_q)) begin
                     rsp_valid <= 1'b1;
                     rsp_data <= bc.rdata;
                     cmd_ready <= 1'b1;
                     state_q <= S_IDLE;
                  end else begin
                     step_q <= step_q + 2'h1;
                     state_q <= S_ISSUE;
                  end
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Per-bank mode tracking
   // ==========================================================
   // Updated when the last bus cycle of a sequence completes; a reset between the
   // cycles is a fresh reset operation and lands here the same way.
   generate
      for (genvar b = 0; b < flash_host_pkg::BANKS; b++) begin : g_bank
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               mode_q[b] <= flash_host_pkg::MODE_READ;
               reset_needed[b] <= 1'b0;
            end else if (state_q == S_WAIT && bc.done && step_q == last_step(op_q)) begin
               case (op_q)
                  flash_host_pkg::OP_RESET: begin
                     // A working bank ignores reset, so its view is kept
                     if (!bank_busy[b]) begin
                        mode_q[b] <= idle_mode(bank_suspended[b]);
                        reset_needed[b] <= 1'b0;
                     end
                  end
                  flash_host_pkg::OP_AUTOSEL: begin
                     if (bank_w == 2'(b)) begin
                        mode_q[b] <= flash_host_pkg::MODE_AUTO;
                        reset_needed[b] <= 1'b1;
                     end
                  end
                  flash_host_pkg::OP_QUERY: begin
                     if (bank_w == 2'(b)) begin
                        mode_q[b] <= flash_host_pkg::MODE_QUERY;
                        reset_needed[b] <= 1'b1;
                     end
                  end
                  default: begin
                     // Status read on a working bank showing a timeout
                     if (bank_w == 2'(b) && bank_busy[b] && bc.rdata[flash_host_pkg::TO_FLAG_BIT]) begin
                        reset_needed[b] <= 1'b1;
                     end
                  end
               endcase
            end
         end
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               bank_mode[4*b +: 4] <= flash_host_pkg::MODE_READ;
            end else begin
               bank_mode[4*b +: 4] <= mode_q[b];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Query data check
   // ==========================================================
   // Sticky until the next query command completes; a read in erase-suspend-read is array or status data and is not checked.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         query_mismatch <= 1'b0;
      end else if (state_q == S_WAIT && bc.done && op_q == flash_host_pkg::OP_READ &&
                   mode_q[bank_w] == flash_host_pkg::MODE_QUERY && expect_w[16] &&
                   bc.rdata != expect_w[15:0]) begin
         query_mismatch <= 1'b1;
      end else if (state_q == S_WAIT && bc.done && op_q == flash_host_pkg::OP_QUERY) begin
         query_mismatch <= 1'b0;
      end
   end

   // ==========================================================
   // Pin engine
   // ==========================================================
   flash_bus_cycle u_cycle (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .bc(bc.engine),
      .ce_n(ce_n),
      .we_n(we_n),
      .oe_n(oe_n),
      .addr(addr),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .dq_in(dq_in)
   );

endmodule
`default_nettype wire

// ==== common/flash_host_pkg.sv ====
// Shared constants, types and the expected query table for the flash host controller.
// Assumes a 16-bit wide parallel flash with four banks, selected by the top address bits.
package flash_host_pkg;

   // ==========================================================
   // Bus widths and bank decode
   // ==========================================================
   localparam int ADDR_W = 23;
   localparam int DATA_W = 16;
   localparam int BANKS = 4;
   localparam int BANK_LSB = 21;
   localparam int BANK_MSB = 22;
   localparam int CNT_W = 4;

   // ==========================================================
   // Timing, in ns and derived clock cycles
   // ==========================================================
   localparam int CLK_NS = 10;
   localparam int T_WP_NS = 35;
   localparam int T_ACC_NS = 70;
   localparam int T_REC_NS = 20;
   localparam int SYNC_LAT = 2;
   localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RD_CYC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);
   localparam logic [CNT_W-1:0] REC_CYC = CNT_W'((T_REC_NS + CLK_NS - 1) / CLK_NS);

   // ==========================================================
   // Command words and addresses
   // ==========================================================
   localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
   localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_AUTOSEL = 16'h0090;
   localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;
   localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;
   localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
   localparam logic [11:0] UNLOCK2_ADDR = 12'h2aa;
   localparam logic [11:0] QUERY_ADDR = 12'h055;
   localparam int TO_FLAG_BIT = 5;

   // ==========================================================
   // User operations
   // ==========================================================
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_RESET = 2'h1;
   localparam logic [1:0] OP_AUTOSEL = 2'h2;
   localparam logic [1:0] OP_QUERY = 2'h3;

   // Per-bank mode, one-hot
   typedef enum logic [3:0] {
      MODE_READ = 4'b0001,
      MODE_ESR = 4'b0010,
      MODE_AUTO = 4'b0100,
      MODE_QUERY = 4'b1000
   } mode_t;

   // ==========================================================
   // Expected query table: {known, value}
   // ==========================================================
   function automatic logic [16:0] query_expect(input logic [7:0] a);
      logic [7:0] v;
      logic k;
      v = 8'h00;
      k = 1'b1;
      case (a)
         8'h10: v = 8'h51;
         8'h11: v = 8'h52;
         8'h12: v = 8'h59;
         8'h1b: v = 8'h27;
         8'h1c: v = 8'h36;
         8'h1d, 8'h1e: v = 8'h00;
         8'h1f: v = 8'h04;
         8'h20, 8'h22: v = 8'h00;
         8'h21: v = 8'h09;
         8'h23: v = 8'h05;
         8'h24, 8'h26: v = 8'h00;
         8'h25: v = 8'h04;
         8'h27: v = 8'h18;
         8'h28: v = 8'h01;
         8'h29, 8'h2a, 8'h2b: v = 8'h00;
         8'h2c: v = 8'h03;
         8'h2d, 8'h35: v = 8'h07;
         8'h2f, 8'h37: v = 8'h20;
         8'h2e, 8'h30, 8'h36, 8'h38: v = 8'h00;
         8'h31: v = 8'hfd;
         8'h32, 8'h33: v = 8'h00;
         8'h34: v = 8'h01;
         8'h39, 8'h3a, 8'h3b, 8'h3c: v = 8'h00;
         8'h40: v = 8'h50;
         8'h41: v = 8'h52;
         8'h42: v = 8'h49;
         8'h43: v = 8'h31;
         8'h44: v = 8'h33;
         8'h45: v = 8'h0c;
         8'h46: v = 8'h02;
         8'h50: v = 8'h01;
         8'h47, 8'h48: v = 8'h01;
         8'h49: v = 8'h07;
         8'h4a: v = 8'he7;
         8'h57: v = 8'h04;
         8'h58, 8'h5b: v = 8'h27;
         8'h59, 8'h5a: v = 8'h60;
         8'h4b: v = 8'h00;
         8'h4c: v = 8'h02;
         8'h4d: v = 8'h85;
         8'h4e: v = 8'h95;
         8'h4f: v = 8'h01;
         default: k = 1'b0;
      endcase
      // Upper data lines are expected at zero
      return {k, 8'h00, v};
   endfunction

endpackage

// ==== common/bus_cycle_if.sv ====
// Carrier between the command sequencer and the pin-level bus cycle engine.
// Assumes both ends run on the same clock; req is a one-cycle pulse, done likewise.
`timescale 1ns/1ps
`default_nettype none
interface bus_cycle_if;
   logic req; // Start one bus cycle
   logic wr; // High for write, low for read
   logic [22:0] addr; // Word address
   logic [15:0] wdata; // Write data
   logic done; // Cycle finished pulse
   logic [15:0] rdata; // Read data, valid with done
   modport master (output req, output wr, output addr, output wdata, input done, input rdata);
   modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ==== logic/flash_bus_cycle.sv ====
// Pin-level engine: runs one asynchronous write or read cycle on the flash pins.
// Assumes the flash data lines arrive asynchronously and are resynchronised here.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle (
   input wire logic clk_sys,
   input wire logic resetn,
   bus_cycle_if.engine bc,
   output logic ce_n,
   output logic we_n,
   output logic oe_n,
   output logic [22:0] addr,
   output logic [15:0] dq_out,
   output logic dq_oe,
   input wire logic [15:0] dq_in
);

   // ==========================================================
   // Declarations
   // ==========================================================
   typedef enum logic [4:0] {
      BC_IDLE = 5'b00001,
      BC_SETUP = 5'b00010,
      BC_STROBE = 5'b00100,
      BC_HOLD = 5'b01000,
      BC_REC = 5'b10000
   } bc_state_t;

   bc_state_t state_q; // Cycle phase
   logic wr_q; // Latched direction
   logic [flash_host_pkg::CNT_W-1:0] cnt_q; // Phase counter
   logic [15:0] sync1_q; // First synchroniser stage
   logic [15:0] sync2_q; // Second synchroniser stage

   // ==========================================================
   // Data line synchroniser
   // ==========================================================
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else begin
         sync1_q <= dq_in;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================================
   // Cycle sequencer
   // ==========================================================
   // Address is set up with chip select before the strobe falls, so the late falling
   // edge is the strobe and address is stable there; the strobe rises before chip
   // select, so data is taken while still driven.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= BC_IDLE;
         wr_q <= 1'b0;
         cnt_q <= '0;
         ce_n <= 1'b1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= '0;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
         bc.done <= 1'b0;
         bc.rdata <= 16'h0000;
      end else begin
         bc.done <= 1'b0;
         case (state_q)
            BC_IDLE: begin
               // Take a request only when fully idle
               if (bc.req) begin
                  wr_q <= bc.wr;
                  addr <= bc.addr;
                  dq_out <= bc.wdata;
                  dq_oe <= bc.wr;
                  ce_n <= 1'b0;
                  state_q <= BC_SETUP;
               end
            end
            BC_SETUP: begin
               // Strobe falls last so the device takes the address here
               we_n <= ~wr_q;
               oe_n <= wr_q;
               cnt_q <= wr_q ? flash_host_pkg::WP_CYC : flash_host_pkg::RD_CYC;
               state_q <= BC_STROBE;
            end
            BC_STROBE: begin
               if (cnt_q <= 4'h1) begin
                  // Strobe rises first; data is still driven at that edge
                  we_n <= 1'b1;
                  oe_n <= 1'b1;
                  if (!wr_q) begin
                     bc.rdata <= sync2_q;
                  end
                  state_q <= BC_HOLD;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            BC_HOLD: begin
               // Chip select and data released one cycle after the strobe
               ce_n <= 1'b1;
               dq_oe <= 1'b0;
               cnt_q <= flash_host_pkg::REC_CYC;
               state_q <= BC_REC;
            end
            BC_REC: begin
               // Recovery gap between cycles
               if (cnt_q <= 4'h1) begin
                  bc.done <= 1'b1;
                  state_q <= BC_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= BC_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== verif/flash_query_host_properties.sv ====
// Checker for the flash host controller: command handshake and flash strobe timing.
// Sees only the top module's ports; bound to every instance of it.
`timescale 1ns/1ps
`default_nettype none
module flash_query_host_checker (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic rsp_refused,
   input wire logic [3:0] bank_busy,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [22:0] addr,
   input wire logic [15:0] dq_out,
   input wire logic dq_oe
);
   // ==========================================
   // Handshake and pin properties
   // One clock domain, so clock and disable are declared once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   refuse_flag_a: assert property (rsp_refused |-> rsp_valid) else $error("refusal without answer");
   answer_pulse_a: assert property (rsp_valid && !(cmd_valid && cmd_ready) |=> !rsp_valid) else $error("answer too wide");
   // Ready stays low from the take until the answer, which must come in bounded time
   take_wait_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready until rsp_valid) else $error("ready early");
   take_bound_a: assert property (cmd_valid && cmd_ready |-> ##[1:60] rsp_valid) else $error("no answer");
   busy_refuse_a: assert property (cmd_valid && cmd_ready && cmd_op == flash_host_pkg::OP_AUTOSEL && |bank_busy
      |-> ##[1:2] rsp_refused) else $error("autoselect not refused");
   refuse_quiet_a: assert property (rsp_refused |-> ce_n && $past(ce_n)) else $error("pins moved on refusal");
   // A write needs the chip selected, the outputs off and the data lines driven
   write_inhibit_a: assert property (!we_n |-> !ce_n && oe_n && dq_oe) else $error("bad write strobes");
   write_width_a: assert property ($fell(we_n) |-> !we_n[*4] ##1 we_n) else $error("write pulse width");
   addr_hold_a: assert property (!we_n ##1 !we_n |-> $stable(addr) && $stable(dq_out)) else $error("moved");
   data_hold_a: assert property ($rose(we_n) |-> dq_oe && $stable(dq_out)) else $error("data hold lost");
   read_float_a: assert property (!oe_n |-> !dq_oe && we_n) else $error("bus fight on read");
   query_take_c: cover property (cmd_valid && cmd_ready && cmd_op == flash_host_pkg::OP_QUERY);
   refused_c: cover property (rsp_refused);
   read_end_c: cover property ($rose(oe_n));
endmodule
bind flash_query_host flash_query_host_checker chk_i (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
   .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .bank_busy(bank_busy),
   .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire

// ==== verif/flash_device_model.sv ====
// Behavioural banked flash: query table, query entry per bank, unlock counting.
// Assumes the host strobes are glitch free; array words are a pattern of the address.
`timescale 1ns/1ps
`default_nettype none
module flash_device_model (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [22:0] addr,
   input wire logic [15:0] dq_out,
   output logic [15:0] dq_in
);
   // ==========================================
   // Query table, locations 10h to 5Bh
   localparam logic [0:75][7:0] TBL = {128'h51525902004000000000002736000004,
      128'h00090005000400180100000003070020, 128'h00fd0000010700200000000000000000,
      128'h50524931330c020101_07e7000285_9501, 96'h010000000000000427606027};
   logic [22:0] a_q = 23'h0; // Address of the current write
   logic [1:0] seq_q = 2'h0; // Unlock cycles seen
   logic [3:0] qry_q = 4'h0; // Banks in query mode, one bit each
   logic [15:0] last_q = 16'h0; // Last word driven; inverted once released
   logic [15:0] word; // Word this address would return
   // Address taken when the later strobe falls
   always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n) a_q <= addr;
   // Data taken at the earlier rise: exactly one strobe is high then
   always @(posedge we_n or posedge ce_n) begin
      if (we_n != ce_n) begin
         seq_q <= 2'h0;
         if (dq_out == 16'h00f0) qry_q <= 4'h0;
         else if (dq_out == 16'h0098 && a_q[11:0] == flash_host_pkg::QUERY_ADDR) qry_q[a_q[22:21]] <= 1'b1;
         else if (dq_out == 16'h00aa && a_q[11:0] == flash_host_pkg::UNLOCK1_ADDR) seq_q <= 2'h1;
         else if (dq_out == 16'h0055 && seq_q == 2'h1) seq_q <= 2'h2;
      end
   end
   // Upper lines are zero in query mode; other reads give array data
   assign word = (qry_q[addr[22:21]] && addr[7:0] >= 8'h10 && addr[7:0] <= 8'h5b) ? {8'h00, TBL[addr[7:0] - 8'h10]}
      : addr[15:0] ^ 16'h5a5a;
   always @(posedge oe_n) last_q <= word;
   // A released bus must not keep the last value
   assign dq_in = (!ce_n && !oe_n) ? word : ~last_q;
endmodule
`default_nettype wire

// ==== verif/flash_query_host_tb.sv ====
// Self-checking bench for the flash host controller with a behavioural flash.
// Assumes a 100 MHz clock; bank busy and suspend inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
module flash_query_host_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [22:0] cmd_addr = 23'h0;
   logic [3:0] bank_busy = 4'h0;
   logic [3:0] bank_suspended = 4'h0;
   logic cmd_ready, rsp_valid, rsp_refused, query_mismatch, ce_n, we_n, oe_n, dq_oe, refd;
   logic [15:0] rsp_data, bank_mode, dq_out, dq_in;
   logic [3:0] reset_needed;
   logic [22:0] addr;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   // Rows: query location, byte expected on the low lines
   logic [15:0] rows [37] = '{16'h1051, 16'h1152, 16'h1259, 16'h1b27, 16'h1c36, 16'h1f04, 16'h2000, 16'h2109,
      16'h2305, 16'h2504, 16'h2718, 16'h2c03, 16'h2d07, 16'h2f20, 16'h31fd, 16'h3401, 16'h3507, 16'h3720, 16'h3c00,
      16'h4050, 16'h4152, 16'h4249, 16'h4331, 16'h4433, 16'h450c, 16'h4602, 16'h4701, 16'h4801, 16'h4907, 16'h4ae7,
      16'h4b00, 16'h4c02, 16'h5001, 16'h5704, 16'h5827, 16'h5960, 16'h5b27};
   always #5 clk_sys = ~clk_sys;
   flash_query_host DUT (.clk_sys, .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_ready, .rsp_valid, .rsp_refused,
      .rsp_data, .bank_busy, .bank_suspended, .bank_mode, .reset_needed, .query_mismatch, .ce_n, .we_n, .oe_n, .addr,
      .dq_out, .dq_oe, .dq_in);
   flash_device_model flash_i (.ce_n, .we_n, .oe_n, .addr, .dq_out, .dq_in);
   // ==========================================
   // Shared tasks
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One command; waits two more edges because the mode output lags by a cycle
   task automatic run(input logic [1:0] op, input logic [22:0] a);
      cmd_op <= op;
      cmd_addr <= a;
      cmd_valid <= 1'b1;
      @(posedge clk_sys);
      while (cmd_ready !== 1'b1) @(posedge clk_sys);
      cmd_valid <= 1'b0;
      @(posedge clk_sys);
      while (rsp_valid !== 1'b1) @(posedge clk_sys);
      refd = rsp_refused;
      repeat (2) @(posedge clk_sys);
   endtask
   // Cuts a hang short; the whole run needs about 900 cycles
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         results();
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk(bank_mode, 16'h1111);
      run(flash_host_pkg::OP_QUERY, 23'h0);
      chk({reset_needed, bank_mode[11:0]}, 16'h1118);
      foreach (rows[i]) begin
         run(flash_host_pkg::OP_READ, {15'h0, rows[i][15:8]});
         chk(rsp_data, {8'h00, rows[i][7:0]});
      end
      chk({15'h0, query_mismatch}, 16'h0);
      run(flash_host_pkg::OP_QUERY, 23'h0);
      chk({15'h0, refd}, 16'h1);
      bank_busy <= 4'h2;
      run(flash_host_pkg::OP_AUTOSEL, 23'h400000);
      chk({15'h0, refd}, 16'h1);
      bank_busy <= 4'h0;
      bank_suspended <= 4'h2;
      run(flash_host_pkg::OP_AUTOSEL, 23'h200000);
      chk({bank_mode[7:4], 11'h0, refd}, 16'h4000);
      run(flash_host_pkg::OP_QUERY, 23'h600000);
      bank_busy <= 4'h8;
      run(flash_host_pkg::OP_QUERY, 23'h600000);
      chk({15'h0, refd}, 16'h1);
      run(flash_host_pkg::OP_RESET, 23'h5abcde);
      chk(bank_mode, 16'h8121);
      bank_busy <= 4'h0;
      bank_suspended <= 4'h0;
      run(flash_host_pkg::OP_RESET, 23'h0);
      chk({bank_mode[11:0], reset_needed}, 16'h1110);
      // Status read on a working bank with the timeout bit set
      bank_busy <= 4'h4;
      run(flash_host_pkg::OP_READ, 23'h400123);
      chk(rsp_data, 16'h5b79);
      chk({12'h0, reset_needed}, 16'h0004);
      results();
   end
endmodule
`default_nettype wire
